/* design/five_unit_rx.sv */
// Five-unit start-stop receiver with shift tracking, function decode and print sequence
//
// Added by the designer: the register addresses and strobed register access.
`timescale 1ns/100ps
module five_unit_rx #(
	parameter int UNIT_CYC = five_unit_rx_pkg::UNIT_CYC_DEF
) (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// Signal line, high while current flows
	input  wire logic        line_pin,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Printer side
	output logic             print_stb,
	output logic      [5:0]  graphic,
	output logic             space_stb,
	output logic             space_sup,
	output logic      [6:0]  column,
	// Function side
	output logic             lf_stb,
	output logic      [1:0]  lf_lines,
	output logic             cr_stb,
	output logic             func_lf,
	output logic             func_cr,
	output logic             func_bell,
	output logic             figures,
	output logic             busy
);

	localparam int TICK_DIV = UNIT_CYC / five_unit_rx_pkg::TICKS_PER_UNIT;
	localparam logic [23:0] TICK_LAST = 24'(TICK_DIV - 1);

	five_unit_rx_pkg::rx_state_e st_q;

	logic        line_m_q;
	logic        line_q;
	logic [23:0] div_q;
	logic        tick;
	logic [4:0]  tcnt_q;
	logic [2:0]  pulse_q;
	logic [4:0]  shreg_q;
	logic [4:0]  code_q;
	logic        fn_q;
	logic        figs_q;
	logic [6:0]  col_q;
	logic        open_q;
	logic        short_q;
	logic        dbl_q;
	logic [3:0]  phase_q;
	logic [6:0]  width_q;
	logic        sample;
	logic        unit_end;
	logic        stop_end;
	logic        start_seen;
	logic        at_end;
	logic        sup;
	logic [4:0]  stop_ticks;

	// Non-printing combinations depend on the shift state for the bell
	function automatic logic is_func(input logic [4:0] c, input logic f);
		is_func = (c == five_unit_rx_pkg::CODE_BLANK) || (c == five_unit_rx_pkg::CODE_CR)
			|| (c == five_unit_rx_pkg::CODE_LF) || (c == five_unit_rx_pkg::CODE_LTRS)
			|| (c == five_unit_rx_pkg::CODE_FIGS) || (f && (c == five_unit_rx_pkg::CODE_BELL));
	endfunction : is_func

	// Two-stage synchroniser; the line is asynchronous to mclk
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			line_m_q <= 1'b1;
			line_q   <= 1'b1;
		end
		else
		begin
			line_m_q <= line_pin;
			line_q   <= line_m_q; // marking is 1, spacing is 0
		end
	end

	// A spacing level on an idle line opens a frame
	assign start_seen = (st_q == five_unit_rx_pkg::S_IDLE) && !line_q;

	// Tick divider restarted at the start edge keeps sampling aligned to it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			div_q <= 24'h000000;
		else if (start_seen || div_q == TICK_LAST)
			div_q <= 24'h000000;
		else
			div_q <= div_q + 24'h000001;
	end

	assign tick = (div_q == TICK_LAST);

	// Stop length follows the 7.42 or 7.0 unit pattern
	assign stop_ticks = short_q ? five_unit_rx_pkg::STOP_SHORT_TICKS
		: five_unit_rx_pkg::STOP_LONG_TICKS;

	// Sample point is a tick inside the unit chosen by software
	assign sample   = tick && (tcnt_q == {1'b0, phase_q});
	assign unit_end = tick && (tcnt_q == five_unit_rx_pkg::UNIT_LAST_TICK);
	assign stop_end = tick && (tcnt_q == stop_ticks - 5'h01);

	// Tick count within the current pulse
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			tcnt_q <= 5'h00;
		else if (start_seen)
			tcnt_q <= 5'h00;
		else if (unit_end && st_q != five_unit_rx_pkg::S_STOP)
			tcnt_q <= 5'h00;
		else if (stop_end && st_q == five_unit_rx_pkg::S_STOP)
			tcnt_q <= 5'h00;
		else if (tick)
			tcnt_q <= tcnt_q + 5'h01;
	end

	// Column and suppression of spacing
	assign at_end = (col_q >= width_q - 7'h01);
	assign sup    = fn_q || at_end;

	// Frame and operating sequence
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			st_q <= five_unit_rx_pkg::S_IDLE;
		else
		begin
			unique case (st_q)
				five_unit_rx_pkg::S_IDLE:
					if (!line_q)
						st_q <= five_unit_rx_pkg::S_START;
				five_unit_rx_pkg::S_START:
					if (sample && line_q)
						st_q <= five_unit_rx_pkg::S_IDLE; // Short glitch, not a start
					else if (unit_end)
						st_q <= five_unit_rx_pkg::S_BITS;
				five_unit_rx_pkg::S_BITS:
					if (unit_end && pulse_q == five_unit_rx_pkg::LAST_PULSE)
						st_q <= five_unit_rx_pkg::S_STOP;
				five_unit_rx_pkg::S_STOP:
					if (sample && !line_q)
						st_q <= five_unit_rx_pkg::S_OPEN; // Stop must mark
					else if (stop_end)
						st_q <= five_unit_rx_pkg::S_LATCH;
				five_unit_rx_pkg::S_LATCH:
					st_q <= five_unit_rx_pkg::S_FUNC;
				five_unit_rx_pkg::S_FUNC:
					st_q <= five_unit_rx_pkg::S_PRINT;
				five_unit_rx_pkg::S_PRINT:
					st_q <= five_unit_rx_pkg::S_SPACE;
				five_unit_rx_pkg::S_SPACE:
					st_q <= five_unit_rx_pkg::S_IDLE;
				five_unit_rx_pkg::S_OPEN:
					if (line_q)
						st_q <= five_unit_rx_pkg::S_IDLE;
				default:
					st_q <= five_unit_rx_pkg::S_IDLE;
			endcase
		end
	end

	// Pulse sampling into the holding register
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			pulse_q <= 3'h0;
			shreg_q <= 5'h00;
		end
		else if (st_q == five_unit_rx_pkg::S_START)
			pulse_q <= 3'h0;
		else if (st_q == five_unit_rx_pkg::S_BITS)
		begin
			if (sample)
				shreg_q[pulse_q] <= line_q;
			if (unit_end)
				pulse_q <= pulse_q + 3'h1;
		end
	end

	// Whole combination is transferred only once the stop pulse is done
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			code_q <= 5'h00;
			fn_q   <= 1'b0;
		end
		else if (st_q == five_unit_rx_pkg::S_LATCH)
		begin
			code_q <= shreg_q;
			fn_q   <= is_func(shreg_q, figs_q);
		end
	end

	// Shift state; shift codes touch nothing else
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			figs_q <= 1'b0;
		else if (st_q == five_unit_rx_pkg::S_FUNC)
		begin
			if (code_q == five_unit_rx_pkg::CODE_LTRS)
				figs_q <= 1'b0;
			else if (code_q == five_unit_rx_pkg::CODE_FIGS)
				figs_q <= 1'b1;
		end
	end

	// Function outputs held from function stage to end of cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			func_lf   <= 1'b0;
			func_cr   <= 1'b0;
			func_bell <= 1'b0;
		end
		else if (st_q == five_unit_rx_pkg::S_FUNC)
		begin
			func_lf   <= (code_q == five_unit_rx_pkg::CODE_LF);
			func_cr   <= (code_q == five_unit_rx_pkg::CODE_CR);
			func_bell <= figs_q && (code_q == five_unit_rx_pkg::CODE_BELL);
		end
		else if (st_q == five_unit_rx_pkg::S_SPACE)
		begin
			func_lf   <= 1'b0;
			func_cr   <= 1'b0;
			func_bell <= 1'b0;
		end
	end

	// Line advance and return strobes fire once, in the cycle after the function stage
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			lf_stb   <= 1'b0;
			lf_lines <= 2'h1;
			cr_stb   <= 1'b0;
		end
		else
		begin
			lf_stb <= (st_q == five_unit_rx_pkg::S_FUNC) && (code_q == five_unit_rx_pkg::CODE_LF);
			cr_stb <= (st_q == five_unit_rx_pkg::S_FUNC) && (code_q == five_unit_rx_pkg::CODE_CR);
			if (st_q == five_unit_rx_pkg::S_FUNC && code_q == five_unit_rx_pkg::CODE_LF)
				lf_lines <= dbl_q ? 2'h2 : 2'h1;
		end
	end

	// One pallet per cycle; functions strike a blank position
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			print_stb <= 1'b0;
			graphic   <= five_unit_rx_pkg::BLANK_PALLET;
			space_sup <= 1'b0;
		end
		else
		begin
			print_stb <= (st_q == five_unit_rx_pkg::S_PRINT);
			if (st_q == five_unit_rx_pkg::S_PRINT)
			begin
				graphic   <= fn_q ? five_unit_rx_pkg::BLANK_PALLET : {figs_q, code_q};
				space_sup <= sup;
			end
		end
	end

	// Horizontal position; return wins over spacing as they never share a cycle
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			col_q     <= 7'h00;
			space_stb <= 1'b0;
		end
		else
		begin
			space_stb <= (st_q == five_unit_rx_pkg::S_SPACE) && !sup;
			if (st_q == five_unit_rx_pkg::S_FUNC && code_q == five_unit_rx_pkg::CODE_CR)
				col_q <= 7'h00;
			else if (st_q == five_unit_rx_pkg::S_SPACE && !sup)
				col_q <= col_q + 7'h01;
		end
	end

	// Open line flag, sticky until software clears it; a new open wins
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			open_q <= 1'b0;
		else if (st_q == five_unit_rx_pkg::S_OPEN)
			open_q <= 1'b1;
		else if (reg_wr && reg_addr == five_unit_rx_pkg::ADDR_STATUS && reg_wdata[five_unit_rx_pkg::ST_OPEN_BIT])
			open_q <= 1'b0;
	end

	// Software settings
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			short_q <= 1'b0;
			dbl_q   <= 1'b0;
			phase_q <= five_unit_rx_pkg::PHASE_RST;
			width_q <= five_unit_rx_pkg::WIDTH_RST;
		end
		else if (reg_wr)
		begin
			if (reg_addr == five_unit_rx_pkg::ADDR_CTRL)
			begin
				short_q <= reg_wdata[five_unit_rx_pkg::CTRL_SHORT_BIT];
				dbl_q   <= reg_wdata[five_unit_rx_pkg::CTRL_DBL_BIT];
				phase_q <= reg_wdata[five_unit_rx_pkg::CTRL_PH_MSB:five_unit_rx_pkg::CTRL_PH_LSB];
			end
			if (reg_addr == five_unit_rx_pkg::ADDR_WIDTH)
				width_q <= reg_wdata[6:0];
		end
	end

	// Read data stand one cycle after the read strobe; unmapped reads give zero
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
		begin
			reg_rdata <= 32'h00000000;
			unique case (reg_addr)
				five_unit_rx_pkg::ADDR_CTRL:
				begin
					reg_rdata[five_unit_rx_pkg::CTRL_SHORT_BIT] <= short_q;
					reg_rdata[five_unit_rx_pkg::CTRL_DBL_BIT]   <= dbl_q;
					reg_rdata[five_unit_rx_pkg::CTRL_PH_MSB:five_unit_rx_pkg::CTRL_PH_LSB] <= phase_q;
				end
				five_unit_rx_pkg::ADDR_WIDTH:
					reg_rdata[6:0] <= width_q;
				five_unit_rx_pkg::ADDR_STATUS:
				begin
					reg_rdata[five_unit_rx_pkg::ST_FIGS_BIT] <= figs_q;
					reg_rdata[five_unit_rx_pkg::ST_BUSY_BIT] <= (st_q != five_unit_rx_pkg::S_IDLE);
					reg_rdata[five_unit_rx_pkg::ST_OPEN_BIT] <= open_q;
					reg_rdata[five_unit_rx_pkg::ST_COL_MSB:five_unit_rx_pkg::ST_COL_LSB] <= col_q;
				end
				five_unit_rx_pkg::ADDR_LAST:
					reg_rdata[6:0] <= {fn_q, figs_q, code_q};
				default:
					reg_rdata <= 32'h00000000;
			endcase
		end
	end

	// Status straight from state
	assign column  = col_q;
	assign figures = figs_q;
	assign busy    = (st_q != five_unit_rx_pkg::S_IDLE);

endmodule : five_unit_rx

/* design/five_unit_rx_pkg.sv */
// Constants, register map and state codes of the five-unit start-stop receiver
// Behaviour
// - Line current flowing is marking (1); no current is spacing (0).
// - Each frame carries five intelligence pulses in sequence, 32 combinations.
// - Frame opens with a spacing start pulse, closes with a marking stop pulse.
// - Standard stop pulse lasts 1.42 units, character 7.42 units.
// - Optional short stop pulse of one unit, character 7.0 units.
// - All five pulses marking selects letters state for following combinations.
// - Pulses 1,2,4,5 marking, 3 spacing, selects figures state.
// - Shift codes only change shift; others decode by current shift state.
// - Reception begins at a spacing start on idle marking line; idle otherwise.
// - Sampling phase within each unit interval is software settable.
// - Decode starts only after all five pulses are held as a combination.
// - After decode, function stage then print stage run in that order.
// - Function code raises its one output, cleared when the cycle ends.
// - Line feed advances paper one or two lines per single/double setting.
// - Carriage return drives the position straight back to the left margin.
// - Each printed graphic advances position one character unless suppressed.
// - Spacing suppressed for non-printing functions and at end of line.
// - At most one graphic per cycle; functions select a blank pallet.
// - Steady marking is idle; steady spacing (open line) is tolerated.
package five_unit_rx_pkg;

	// Timing: unit interval and clock period in ns
	localparam int UNIT_NS        = 22_000_000;
	localparam int CLK_NS         = 100;
	localparam int UNIT_CYC_DEF   = UNIT_NS / CLK_NS;
	localparam int TICKS_PER_UNIT = 16;
	localparam int STOP_LONG_X100 = 142;
	// Least time, so the long stop rounds up to whole ticks
	localparam logic [4:0] STOP_LONG_TICKS  = 5'((STOP_LONG_X100 * TICKS_PER_UNIT + 99) / 100);
	localparam logic [4:0] STOP_SHORT_TICKS = 5'(TICKS_PER_UNIT);
	localparam logic [4:0] UNIT_LAST_TICK   = 5'(TICKS_PER_UNIT - 1);
	localparam logic [2:0] LAST_PULSE       = 3'h4;

	// Code combinations, pulse one in bit 0
	localparam logic [4:0] CODE_LTRS  = 5'h1f;
	localparam logic [4:0] CODE_FIGS  = 5'h1b;
	localparam logic [4:0] CODE_CR    = 5'h08;
	localparam logic [4:0] CODE_LF    = 5'h02;
	localparam logic [4:0] CODE_BLANK = 5'h00;
	localparam logic [4:0] CODE_BELL  = 5'h05;
	localparam logic [5:0] BLANK_PALLET = 6'h00;

	// Register offsets
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_WIDTH  = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_LAST   = 8'h0c;

	// Control fields and reset values
	localparam int CTRL_SHORT_BIT = 0;
	localparam int CTRL_DBL_BIT   = 1;
	localparam int CTRL_PH_LSB    = 2;
	localparam int CTRL_PH_MSB    = 5;
	localparam logic [3:0] PHASE_RST = 4'h8;
	localparam logic [6:0] WIDTH_RST = 7'h48;

	// Status fields
	localparam int ST_FIGS_BIT = 0;
	localparam int ST_BUSY_BIT = 1;
	localparam int ST_OPEN_BIT = 2;
	localparam int ST_COL_LSB  = 8;
	localparam int ST_COL_MSB  = 14;

	// Receiver sequence states
	typedef enum logic [3:0] {
		S_IDLE  = 4'b0000,
		S_START = 4'b0001,
		S_BITS  = 4'b0010,
		S_STOP  = 4'b0011,
		S_LATCH = 4'b0100,
		S_FUNC  = 4'b0101,
		S_PRINT = 4'b0110,
		S_SPACE = 4'b0111,
		S_OPEN  = 4'b1000
	} rx_state_e;

endpackage : five_unit_rx_pkg

/* testbench/five_unit_rx_monitor.sv */
// Concurrent checks on the receiver's printer and function outputs
`timescale 1ns/100ps
module five_unit_rx_monitor #(
	parameter int UNIT_CYC = 160
) (
	// Clock, reset and line
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       line_pin,
	// Printer side
	input wire logic       print_stb,
	input wire logic [5:0] graphic,
	input wire logic       space_stb,
	input wire logic       space_sup,
	input wire logic [6:0] column,
	// Function side
	input wire logic       lf_stb,
	input wire logic       cr_stb,
	input wire logic       func_lf,
	input wire logic       func_cr,
	input wire logic       func_bell,
	input wire logic       busy
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// A free print cycle is followed by exactly one spacing strobe
	sequence s_print_free;
		print_stb && !space_sup;
	endsequence
	sequence s_space_once;
		space_stb ##1 !space_stb;
	endsequence
	property p_space_follows;
		s_print_free |=> s_space_once;
	endproperty
	a_space_follows: assert property (p_space_follows)
		else $error("spacing strobe missing after print");
	property p_space_cause;
		space_stb |-> $past(print_stb) && !$past(space_sup);
	endproperty
	a_space_cause: assert property (p_space_cause)
		else $error("spacing strobe without a free print");
	property p_col_step;
		space_stb |-> column == $past(column) + 7'h01;
	endproperty
	a_col_step: assert property (p_col_step)
		else $error("column did not step by one");
	property p_sup_hold;
		print_stb && space_sup |=> !space_stb && $stable(column);
	endproperty
	a_sup_hold: assert property (p_sup_hold)
		else $error("spacing despite suppression");
	property p_cr_home;
		cr_stb |-> ##[0:2] column == 7'h00;
	endproperty
	a_cr_home: assert property (p_cr_home)
		else $error("return did not reach left margin");
	property p_func_blank;
		print_stb && (func_lf || func_cr || func_bell) |-> graphic == 6'h00 && space_sup;
	endproperty
	a_func_blank: assert property (p_func_blank)
		else $error("function printed a pallet");
	property p_func_order;
		lf_stb || cr_stb |-> ##1 print_stb;
	endproperty
	a_func_order: assert property (p_func_order)
		else $error("print stage not right after function");
	property p_func_clear;
		$rose(func_lf) |-> func_lf [*2] ##1 !func_lf;
	endproperty
	a_func_clear: assert property (p_func_clear)
		else $error("function output not cleared");
	property p_one_print;
		print_stb |=> !print_stb [*8];
	endproperty
	a_one_print: assert property (p_one_print)
		else $error("second print in one cycle");
	property p_start;
		$fell(line_pin) && !busy |-> ##[2:5] busy;
	endproperty
	a_start: assert property (p_start)
		else $error("start pulse not taken");
endmodule : five_unit_rx_monitor

bind five_unit_rx five_unit_rx_monitor #(.UNIT_CYC(UNIT_CYC)) u_mon (.mclk, .rst, .line_pin, .print_stb, .graphic,
	.space_stb, .space_sup, .column, .lf_stb, .cr_stb, .func_lf, .func_cr, .func_bell, .busy);

/* testbench/code_sender.sv */
// Remote start-stop transmitter model driving the signal line
`timescale 1ns/100ps
module code_sender #(
	parameter int UNIT_CYC = 160
) (
	// Clock and line
	input  wire logic mclk,
	output logic      line_pin
);
	// Line rests marking while no character is sent
	initial line_pin = 1'h1;

	// One level for n cycles, launched at a rising edge
	task automatic hold(input logic lvl, input int n);
		@(posedge mclk);
		line_pin <= lvl;
		repeat (n - 1) @(posedge mclk);
	endtask : hold

	// Whole frame; pulse one goes first, from code bit 0
	task automatic send(input logic [4:0] code, input logic short_stop);
		hold(1'h0, UNIT_CYC);
		for (int i = 0; i < 5; i++)
			hold(code[i], UNIT_CYC);
		hold(1'h1, short_stop ? UNIT_CYC : (UNIT_CYC * 142 + 99) / 100);
	endtask : send
endmodule : code_sender

/* testbench/tb.sv */
// Self-checking testbench for the five-unit receiver
`timescale 1ns/100ps
module tb;
	localparam int UC = 160;
	// Design signals
	logic        mclk = 1'h0;
	logic        rst = 1'h1;
	logic        line_pin;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'h0;
	logic        reg_rd = 1'h0;
	logic [31:0] reg_rdata;
	logic        print_stb, space_stb, space_sup, lf_stb, cr_stb;
	logic        func_lf, func_cr, func_bell, figures, busy;
	logic [5:0]  graphic;
	logic [6:0]  column;
	logic [1:0]  lf_lines;
	// Bench bookkeeping
	int          err_total = 0;
	int          check_count = 0;
	int          n_print = 0;
	int          n_space = 0;
	int          n_lf = 0;
	logic        bell_seen = 1'h0;
	logic        short_mode = 1'h0;
	logic [31:0] v;

	five_unit_rx #(.UNIT_CYC(UC)) u_dut (.mclk, .rst, .line_pin, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .print_stb, .graphic, .space_stb, .space_sup, .column, .lf_stb, .lf_lines, .cr_stb,
		.func_lf, .func_cr, .func_bell, .figures, .busy);
	code_sender #(.UNIT_CYC(UC)) u_tx (.mclk, .line_pin);

	// Clock at 10 MHz
	always #50 mclk = ~mclk;

	// Strobe counts, since pulses stand for one cycle only
	always @(posedge mclk)
	begin
		if (print_stb === 1'h1) n_print++;
		if (space_stb === 1'h1) n_space++;
		if (lf_stb === 1'h1) n_lf++;
		if (func_bell === 1'h1) bell_seen = 1'h1;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge mclk);
		reg_wr <= 1'h0;
	endtask : wr

	// Read data stand from the cycle after the strobe until the next read
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge mclk);
		reg_rd <= 1'h0;
		@(negedge mclk);
		d = reg_rdata;
	endtask : rd

	// One frame, then room for the whole operating sequence
	task automatic tx(input logic [4:0] c);
		u_tx.send(c, short_mode);
		repeat (24) @(posedge mclk);
		@(negedge mclk);
	endtask : tx

	task automatic t_regs();
		rd(8'h00, v);
		chk("ctrl", v, 32'h20);
		rd(8'h04, v);
		chk("width", v, 32'h48);
		rd(8'h08, v);
		chk("status", v, 32'h0);
		rd(8'h10, v);
		chk("unmapped", v, 32'h0);
	endtask : t_regs

	task automatic t_shift();
		tx(5'h1f);
		chk("figures", figures, 1'h0);
		tx(5'h03);
		chk("graphic", graphic, 6'h03);
		chk("column", column, 7'h01);
		tx(5'h1b);
		chk("figures", figures, 1'h1);
		chk("graphic", graphic, 6'h00);
		tx(5'h03);
		chk("graphic", graphic, 6'h23);
		rd(8'h0c, v);
		chk("last", v, 32'h23);
		chk("column", column, 7'h02);
	endtask : t_shift

	task automatic t_funcs();
		tx(5'h08);
		chk("column", column, 7'h00);
		wr(8'h00, 32'h22);
		tx(5'h02);
		chk("lf_lines", lf_lines, 2'h2);
		wr(8'h00, 32'h20);
		tx(5'h02);
		chk("lf_lines", lf_lines, 2'h1);
		chk("lf_count", n_lf, 2);
		tx(5'h05);
		chk("bell", bell_seen, 1'h1);
		chk("graphic", graphic, 6'h00);
		tx(5'h1f);
		chk("column", column, 7'h00);
		// Blank is a function; the bell code in letters is an ordinary graphic
		tx(5'h00);
		chk("graphic", graphic, 6'h00);
		chk("column", column, 7'h00);
		tx(5'h05);
		chk("graphic", graphic, 6'h05);
		chk("column", column, 7'h01);
		chk("prints", n_print, 11);
		chk("spaces", n_space, 3);
	endtask : t_funcs

	// Narrow line: position sticks at width minus one
	task automatic t_eol();
		wr(8'h04, 32'h03);
		repeat (4) tx(5'h01);
		chk("column", column, 7'h02);
		chk("space_sup", space_sup, 1'h1);
		tx(5'h08);
		chk("column", column, 7'h00);
		wr(8'h04, 32'h48);
	endtask : t_eol

	// Back-to-back frames, long stop at phase 8, short stop at phase 3
	task automatic t_timing();
		int p;
		for (int m = 0; m < 2; m++)
		begin
			wr(8'h00, m ? 32'h0d : 32'h20);
			short_mode = m[0];
			p = n_print;
			// Lone frame: busy must end only after the stop length of this mode
			u_tx.send(5'h01, short_mode);
			repeat (5) @(posedge mclk);
			@(negedge mclk);
			chk("busy_stop", busy, 1'h1);
			repeat (7) @(posedge mclk);
			@(negedge mclk);
			chk("busy_end", busy, 1'h0);
			u_tx.send(5'h06, short_mode);
			tx(5'h01);
			chk("graphic", graphic, 6'h01);
			chk("prints", n_print - p, 3);
		end
	endtask : t_timing

	// Glitch shorter than the sample phase, then an open line
	task automatic t_open();
		int p;
		wr(8'h00, 32'h20);
		short_mode = 1'h0;
		p = n_print;
		u_tx.hold(1'h0, 60);
		u_tx.hold(1'h1, 2 * UC);
		chk("busy", busy, 1'h0);
		u_tx.hold(1'h0, 15 * UC);
		u_tx.hold(1'h1, 2 * UC);
		rd(8'h08, v);
		chk("open", v[2], 1'h1);
		chk("prints", n_print - p, 0);
		wr(8'h08, 32'h4);
		rd(8'h08, v);
		chk("open", v[2], 1'h0);
		tx(5'h1a);
		chk("graphic", graphic, 6'h1a);
	endtask : t_open

	task automatic tally_and_finish();
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : tally_and_finish

	// Main sequence
	initial
	begin
		repeat (12) @(posedge mclk);
		rst <= 1'h0;
		t_regs();
		t_shift();
		t_funcs();
		t_eol();
		t_timing();
		t_open();
		tally_and_finish();
	end

	// Watchdog, well above the roughly 31000 cycles the run needs
	initial
	begin
		repeat (45000) @(posedge mclk);
		err_total++;
		tally_and_finish();
	end
endmodule : tb
